// >>> design/sbsc_pkg.sv
// shared constants, types and decode helpers for the burst sram link
package sbsc_pkg;
  // memory geometry, x36 organisation
  localparam int ADDR_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = LANE_W * LANES;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_LAST = 2'h3;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // host register map, byte offsets on the control port
  localparam int REG_ADDR_W = 8;
  localparam logic [REG_ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_ADDR_W-1:0] REG_ADDR = 8'h04;
  localparam logic [REG_ADDR_W-1:0] REG_CMD = 8'h08;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [REG_ADDR_W-1:0] REG_WDATA0 = 8'h10;
  localparam logic [REG_ADDR_W-1:0] REG_RDATA0 = 8'h20;
  localparam logic [REG_ADDR_W-1:0] REG_BLOCK_MASK = 8'hF0;
  localparam int SLOT_LSB = 2;

  // field positions
  localparam int CTRL_ORDER_BIT = 0;
  localparam int CTRL_FT_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BURST_BIT = 2;
  localparam int CMD_LANE_LSB = 4;
  localparam int CMD_ALL_BIT = 8;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_DUMMY = 2'h2;

  // command seen by the memory on one clock edge
  typedef enum {CMD_DESELECT, CMD_BEGIN_READ, CMD_BEGIN_WRITE, CMD_CONTINUE, CMD_SUSPEND}
    sbsc_cmd_type;

  // chip counts as enabled only for high-true high and both low-true low
  function automatic logic sbsc_enabled(input logic e1_n, input logic e2, input logic e3_n);
    return e2 & ~e1_n & ~e3_n;
  endfunction : sbsc_enabled

  // write decision: false only when both write controls are high
  function automatic logic sbsc_write(input logic all_n, input logic qual_n);
    return ~all_n | ~qual_n;
  endfunction : sbsc_write
endpackage : sbsc_pkg

// >>> design/sbsc_bus_if.sv
// synchronous sram bus between the controller and the memory
`timescale 1ns/1ps
interface sbsc_bus_if;
  import sbsc_pkg::*;
  logic [ADDR_W-1:0] address;
  logic chip_enable_primary_n;
  logic chip_enable_high_true;
  logic chip_enable_third_n;
  logic processor_addr_strobe_n;
  logic controller_addr_strobe_n;
  logic burst_advance_n;
  logic all_lane_write_n;
  logic lane_write_qualifier_n;
  logic lane_a_write_en_n;
  logic lane_b_write_en_n;
  logic lane_c_write_en_n;
  logic lane_d_write_en_n;
  logic output_enable_n;
  logic burst_order_select_n;
  logic flow_through_select_n;
  logic sleep_request;
  logic [DATA_W-1:0] dq_host_out;
  logic dq_host_oe;
  logic [DATA_W-1:0] dq_mem_out;
  logic dq_mem_oe;
  logic [DATA_W-1:0] dq;

  // resolved data pins; an undriven bus reads as zero
  assign dq = dq_mem_oe ? dq_mem_out : (dq_host_oe ? dq_host_out : '0);

  modport memory (
    input address, chip_enable_primary_n, chip_enable_high_true, chip_enable_third_n,
    input processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    input all_lane_write_n, lane_write_qualifier_n, lane_a_write_en_n,
    input lane_b_write_en_n, lane_c_write_en_n, lane_d_write_en_n, output_enable_n,
    input burst_order_select_n, flow_through_select_n, sleep_request, dq,
    output dq_mem_out, dq_mem_oe
  );
  modport host (
    output address, chip_enable_primary_n, chip_enable_high_true, chip_enable_third_n,
    output processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    output all_lane_write_n, lane_write_qualifier_n, lane_a_write_en_n,
    output lane_b_write_en_n, lane_c_write_en_n, lane_d_write_en_n, output_enable_n,
    output burst_order_select_n, flow_through_select_n, sleep_request,
    output dq_host_out, dq_host_oe,
    input dq
  );
endinterface : sbsc_bus_if

// >>> design/sbsc_burst_counter.sv
// two-bit burst address counter, linear or interleaved order
`timescale 1ns/1ps
module sbsc_burst_counter
  import sbsc_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // counter control
  input wire logic load,
  input wire logic advance,
  input wire logic interleaved,
  input wire logic [BURST_W-1:0] start_low,
  // address low bits now and after one step
  output logic [BURST_W-1:0] current_low,
  output logic [BURST_W-1:0] stepped_low
);
  logic [BURST_W-1:0] base;
  logic [BURST_W-1:0] count;
  logic [BURST_W-1:0] count_step;

  // count wraps to its start on the fifth clock of a burst
  assign count_step = count + BURST_STEP;
  assign current_low = interleaved ? (base ^ count) : (base + count);
  assign stepped_low = interleaved ? (base ^ count_step) : (base + count_step);

  // load on a new burst, step on advance, hold otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      base <= BURST_FIRST;
      count <= BURST_FIRST;
    end else if (clk_en) begin
      if (load) begin
        base <= start_low;
        count <= BURST_FIRST;
      end else if (advance) begin
        count <= count_step;
      end
    end
  end
endmodule : sbsc_burst_counter

// >>> design/sbsc_memory.sv
// memory end: command decode, burst addressing, lane writes, read path
`timescale 1ns/1ps
module sbsc_memory
  import sbsc_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // synchronous sram bus
  sbsc_bus_if.memory bus,
  // status
  output logic standby,
  output logic write_done
);
  logic [DATA_W-1:0] array_word;
  sbsc_cmd_type cmd;
  logic enabled;
  logic write_now;
  logic read_now;
  logic [LANES-1:0] lane_en_n;
  logic [LANES-1:0] lane_mask;
  logic [ADDR_W-1:0] addr_now;
  logic [ADDR_W-BURST_W-1:0] addr_high;
  logic [BURST_W-1:0] current_low;
  logic [BURST_W-1:0] stepped_low;
  logic load;
  logic advance;
  logic [DATA_W-1:0] read_stage;
  logic [DATA_W-1:0] data_out;
  logic read_prev;
  logic drive;
  logic interleaved;
  logic flow_through;

  // mode pins: high order pin is interleaved, low flow pin bypasses
  assign interleaved = bus.burst_order_select_n;
  assign flow_through = ~bus.flow_through_select_n;

  // chip enable combination
  assign enabled = sbsc_enabled(bus.chip_enable_primary_n, bus.chip_enable_high_true,
                                bus.chip_enable_third_n);

  // per-lane write enables, lane a in the low bits
  assign lane_en_n = {bus.lane_d_write_en_n, bus.lane_c_write_en_n,
                      bus.lane_b_write_en_n, bus.lane_a_write_en_n};

  // lanes written this cycle; all-lane write ignores the others
  always_comb begin
    if (!bus.all_lane_write_n) begin
      lane_mask = '1;
    end else if (!bus.lane_write_qualifier_n) begin
      lane_mask = ~lane_en_n;
    end else begin
      lane_mask = '0;
    end
  end

  // command decode, processor strobe only counts with primary enable low
  always_comb begin
    cmd = CMD_SUSPEND;
    if (standby) begin
      cmd = CMD_DESELECT;
    end else if (!bus.processor_addr_strobe_n && !bus.chip_enable_primary_n) begin
      if (enabled) begin
        cmd = CMD_BEGIN_READ;
      end else begin
        cmd = CMD_DESELECT;
      end
    end else if (!bus.controller_addr_strobe_n) begin
      if (!enabled) begin
        cmd = CMD_DESELECT;
      end else if (sbsc_write(bus.all_lane_write_n, bus.lane_write_qualifier_n)) begin
        cmd = CMD_BEGIN_WRITE;
      end else begin
        cmd = CMD_BEGIN_READ;
      end
    end else if (!bus.burst_advance_n) begin
      cmd = CMD_CONTINUE;
    end else begin
      cmd = CMD_SUSPEND;
    end
  end

  // direction of the access; continue and suspend follow the write decision
  always_comb begin
    write_now = 1'b0;
    read_now = 1'b0;
    case (cmd)
      CMD_DESELECT: begin
        write_now = 1'b0;
        read_now = 1'b0;
      end
      CMD_BEGIN_READ: begin
        read_now = 1'b1;
      end
      CMD_BEGIN_WRITE: begin
        write_now = 1'b1;
      end
      CMD_CONTINUE, CMD_SUSPEND: begin
        write_now = sbsc_write(bus.all_lane_write_n, bus.lane_write_qualifier_n);
        read_now = ~write_now;
      end
      default: begin
        write_now = 1'b0;
        read_now = 1'b0;
      end
    endcase
  end

  // counter steering; output enable is not looked at, so dummy reads step too
  assign load = (cmd == CMD_BEGIN_READ) || (cmd == CMD_BEGIN_WRITE);
  assign advance = (cmd == CMD_CONTINUE);

  sbsc_burst_counter u_counter (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .load(load),
    .advance(advance),
    .interleaved(interleaved),
    .start_low(bus.address[BURST_W-1:0]),
    .current_low(current_low),
    .stepped_low(stepped_low)
  );

  // address used this cycle: external, next or current
  always_comb begin
    if (load) begin
      addr_now = bus.address;
    end else if (advance) begin
      addr_now = {addr_high, stepped_low};
    end else begin
      addr_now = {addr_high, current_low};
    end
  end

  // upper address bits held for the whole burst
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_high <= '0;
    end else if (clk_en && load) begin
      addr_high <= bus.address[ADDR_W-1:BURST_W];
    end
  end

  // one array per lane so each has a single writer; data taken with the address
  for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [DEPTH];
    assign array_word[lane*LANE_W +: LANE_W] = lane_mem[addr_now];
    always_ff @(posedge clk) begin
      if (clk_en && write_now && lane_mask[lane]) begin
        lane_mem[addr_now] <= bus.dq[lane*LANE_W +: LANE_W];
      end
    end
  end

  // pipelined read data waits one more edge in the output register
  always_ff @(posedge clk) begin
    if (reset) begin
      read_stage <= '0;
      data_out <= '0;
    end else if (clk_en) begin
      read_stage <= read_now ? array_word : read_stage;
      if (flow_through) begin
        data_out <= read_now ? array_word : data_out;
      end else begin
        data_out <= read_stage;
      end
    end
  end

  // driver enable from the synchronous side; writes always float the pins
  always_ff @(posedge clk) begin
    if (reset) begin
      read_prev <= 1'b0;
      drive <= 1'b0;
    end else if (clk_en) begin
      read_prev <= read_now;
      if (flow_through) begin
        drive <= read_now;
      end else begin
        drive <= read_prev & ~write_now & ~standby;
      end
    end
  end

  // output enable high cuts the drivers at once, low only frees read drive
  assign bus.dq_mem_oe = drive & ~bus.output_enable_n;
  assign bus.dq_mem_out = data_out;

  // standby follows the sleep input
  always_ff @(posedge clk) begin
    if (reset) begin
      standby <= 1'b0;
    end else if (clk_en) begin
      standby <= bus.sleep_request;
    end
  end

  // one-cycle mark after each write edge
  always_ff @(posedge clk) begin
    if (reset) begin
      write_done <= 1'b0;
    end else if (clk_en) begin
      write_done <= write_now;
    end
  end
endmodule : sbsc_memory

// >>> design/sbsc_host.sv
// controller end: register port, burst sequencing and read capture
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module sbsc_host
  import sbsc_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // synchronous sram bus
  sbsc_bus_if.host bus,
  // register port
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata
);
  typedef enum {ST_IDLE, ST_TURN, ST_BEAT, ST_DRAIN} sbsc_state_type;
  sbsc_state_type state;
  logic [CTRL_W-1:0] ctrl;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata [BURST_LAST+1];
  logic [DATA_W-1:0] rdata [BURST_LAST+1];
  logic [1:0] op;
  logic burst;
  logic all_lanes;
  logic [LANES-1:0] lanes;
  logic [BURST_W-1:0] beat;
  logic last_read;
  logic start;
  logic [2:0] tok_valid;
  logic [BURST_W-1:0] tok_idx [3];
  logic cap_valid;
  logic [BURST_W-1:0] cap_idx;

  // word slot inside a four-word block
  function automatic logic [BURST_W-1:0] slot(input logic [REG_ADDR_W-1:0] a);
    return a[SLOT_LSB +: BURST_W];
  endfunction : slot

  assign start = reg_write && (reg_addr == REG_CMD) && (state == ST_IDLE);

  // software registers; commands while busy are dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      addr_reg <= '0;
      op <= OP_READ;
      burst <= 1'b0;
      all_lanes <= 1'b0;
      lanes <= '0;
    end else if (clk_en && reg_write) begin
      if (reg_addr == REG_CTRL) begin
        ctrl <= reg_wdata[CTRL_W-1:0];
      end
      if (reg_addr == REG_ADDR) begin
        addr_reg <= reg_wdata[ADDR_W-1:0];
      end
      if (start) begin
        op <= reg_wdata[CMD_OP_LSB +: 2];
        burst <= reg_wdata[CMD_BURST_BIT];
        lanes <= reg_wdata[CMD_LANE_LSB +: LANES];
        all_lanes <= reg_wdata[CMD_ALL_BIT];
      end
      if ((reg_addr & REG_BLOCK_MASK) == REG_WDATA0) begin
        wdata[slot(reg_addr)] <= reg_wdata;
      end
    end
  end

  // read port, answer in the following cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_read) begin
        if (reg_addr == REG_CTRL) reg_rdata <= DATA_W'(ctrl);
        if (reg_addr == REG_ADDR) reg_rdata <= DATA_W'(addr_reg);
        if (reg_addr == REG_STATUS) reg_rdata <= DATA_W'(state != ST_IDLE);
        if ((reg_addr & REG_BLOCK_MASK) == REG_WDATA0) reg_rdata <= wdata[slot(reg_addr)];
        if ((reg_addr & REG_BLOCK_MASK) == REG_RDATA0) reg_rdata <= rdata[slot(reg_addr)];
      end
    end
  end

  // sequencer; bus pins change with the state so they come from flops
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      beat <= BURST_FIRST;
      last_read <= 1'b0;
      bus.address <= '0;
      bus.chip_enable_primary_n <= 1'b1;
      bus.chip_enable_high_true <= 1'b0;
      bus.chip_enable_third_n <= 1'b1;
      bus.processor_addr_strobe_n <= 1'b1;
      bus.controller_addr_strobe_n <= 1'b0;
      bus.burst_advance_n <= 1'b1;
      bus.all_lane_write_n <= 1'b1;
      bus.lane_write_qualifier_n <= 1'b1;
      {bus.lane_d_write_en_n, bus.lane_c_write_en_n,
       bus.lane_b_write_en_n, bus.lane_a_write_en_n} <= '1;
      bus.output_enable_n <= 1'b1;
      bus.dq_host_out <= '0;
      bus.dq_host_oe <= 1'b0;
    end else if (clk_en) begin
      // idle cycles are deselects: controller strobe low, chip disabled
      bus.controller_addr_strobe_n <= 1'b0;
      bus.chip_enable_primary_n <= 1'b1;
      bus.chip_enable_high_true <= 1'b0;
      bus.chip_enable_third_n <= 1'b1;
      bus.burst_advance_n <= 1'b1;
      bus.all_lane_write_n <= 1'b1;
      bus.lane_write_qualifier_n <= 1'b1;
      bus.dq_host_oe <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start && reg_wdata[CMD_OP_LSB +: 2] == OP_WRITE && last_read) begin
            state <= ST_TURN;
            bus.output_enable_n <= 1'b1;
          end else if (start) begin
            state <= ST_BEAT;
            beat <= BURST_FIRST;
            bus.address <= addr_reg;
            bus.chip_enable_primary_n <= 1'b0;
            bus.chip_enable_high_true <= 1'b1;
            bus.chip_enable_third_n <= 1'b0;
            bus.all_lane_write_n <= ~(reg_wdata[CMD_OP_LSB +: 2] == OP_WRITE
                                      && reg_wdata[CMD_ALL_BIT]);
            bus.lane_write_qualifier_n <= ~(reg_wdata[CMD_OP_LSB +: 2] == OP_WRITE
                                            && !reg_wdata[CMD_ALL_BIT]);
            {bus.lane_d_write_en_n, bus.lane_c_write_en_n, bus.lane_b_write_en_n,
             bus.lane_a_write_en_n} <= ~reg_wdata[CMD_LANE_LSB +: LANES];
            bus.dq_host_out <= wdata[BURST_FIRST];
            bus.dq_host_oe <= reg_wdata[CMD_OP_LSB +: 2] == OP_WRITE;
            bus.output_enable_n <= reg_wdata[CMD_OP_LSB +: 2] != OP_READ;
          end
        end
        ST_TURN: begin
          // output enable high for a full cycle, now the latched write begins
          state <= ST_BEAT;
          beat <= BURST_FIRST;
          last_read <= 1'b0;
          bus.address <= addr_reg;
          bus.chip_enable_primary_n <= 1'b0;
          bus.chip_enable_high_true <= 1'b1;
          bus.chip_enable_third_n <= 1'b0;
          bus.all_lane_write_n <= ~all_lanes;
          bus.lane_write_qualifier_n <= all_lanes;
          {bus.lane_d_write_en_n, bus.lane_c_write_en_n, bus.lane_b_write_en_n,
           bus.lane_a_write_en_n} <= ~lanes;
          bus.dq_host_out <= wdata[BURST_FIRST];
          bus.dq_host_oe <= 1'b1;
        end
        ST_BEAT: begin
          if (!burst || beat == BURST_LAST) begin
            state <= ST_DRAIN;
            last_read <= op != OP_WRITE;
          end else begin
            // continuation beats: both strobes high, advance low
            beat <= beat + BURST_STEP;
            bus.controller_addr_strobe_n <= 1'b1;
            bus.burst_advance_n <= 1'b0;
            bus.all_lane_write_n <= ~(op == OP_WRITE && all_lanes);
            bus.lane_write_qualifier_n <= ~(op == OP_WRITE && !all_lanes);
            bus.dq_host_out <= wdata[beat + BURST_STEP];
            bus.dq_host_oe <= op == OP_WRITE;
          end
        end
        ST_DRAIN: begin
          if (tok_valid == '0 && !cap_valid) begin
            state <= ST_IDLE;
            bus.output_enable_n <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // mode pins straight from the control register
  always_ff @(posedge clk) begin
    if (reset) begin
      bus.burst_order_select_n <= 1'b0;
      bus.flow_through_select_n <= 1'b1;
      bus.sleep_request <= 1'b0;
    end else if (clk_en) begin
      bus.burst_order_select_n <= ctrl[CTRL_ORDER_BIT];
      bus.flow_through_select_n <= ~ctrl[CTRL_FT_BIT];
      bus.sleep_request <= ctrl[CTRL_SLEEP_BIT];
    end
  end

  // read tokens follow each real read beat to its data edge
  assign cap_valid = ctrl[CTRL_FT_BIT] ? tok_valid[1] : tok_valid[2];
  assign cap_idx = ctrl[CTRL_FT_BIT] ? tok_idx[1] : tok_idx[2];

  always_ff @(posedge clk) begin
    if (reset) begin
      tok_valid <= '0;
      for (int i = 0; i < 3; i++) tok_idx[i] <= BURST_FIRST;
    end else if (clk_en) begin
      tok_valid <= {tok_valid[1:0], (start && reg_wdata[CMD_OP_LSB +: 2] == OP_READ)
                    || (state == ST_BEAT && op == OP_READ && burst && beat != BURST_LAST)};
      tok_idx[0] <= (state == ST_BEAT) ? beat + BURST_STEP : BURST_FIRST;
      tok_idx[1] <= tok_idx[0];
      tok_idx[2] <= tok_idx[1];
      if (cap_valid) begin
        rdata[cap_idx] <= bus.dq;
      end
    end
  end
endmodule : sbsc_host

// >>> bench/sbsc_assertions.sv
// concurrent checks on the sram bus between host and memory
`timescale 1ns/1ps
module sbsc_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus controls
  input wire logic chip_enable_primary_n,
  input wire logic chip_enable_high_true,
  input wire logic chip_enable_third_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic all_lane_write_n,
  input wire logic lane_write_qualifier_n,
  input wire logic output_enable_n,
  input wire logic flow_through_select_n,
  input wire logic sleep_request,
  // data pin drive
  input wire logic dq_host_oe,
  input wire logic dq_mem_oe
);
  // decoded command terms
  wire logic en = chip_enable_high_true & ~chip_enable_primary_n & ~chip_enable_third_n;
  wire logic wr = ~all_lane_write_n | ~lane_write_qualifier_n;
  wire logic begin_rd = en & ~controller_addr_strobe_n & ~wr & ~sleep_request;
  wire logic begin_wr = en & ~controller_addr_strobe_n & processor_addr_strobe_n & wr;
  wire logic desel = ~controller_addr_strobe_n & ~en;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // read steps
  sequence s_rd_pipe; begin_rd & ~output_enable_n & flow_through_select_n; endsequence
  sequence s_keep; ~output_enable_n & ~sleep_request & ~begin_wr; endsequence
  property p_oe_gate; output_enable_n |-> !dq_mem_oe; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("drive with oe off");
  property p_wr_quiet; begin_wr |-> ##1 !dq_mem_oe; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("drive after write");
  property p_desel; desel ##1 desel |-> ##1 !dq_mem_oe; endproperty
  a_desel: assert property (p_desel) else $error("drive after deselect");
  property p_pipe; s_rd_pipe ##1 s_keep |-> ##1 (dq_mem_oe | output_enable_n); endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline read late");
  property p_flow;
    begin_rd & ~output_enable_n & ~flow_through_select_n |-> ##1 (dq_mem_oe | output_enable_n);
  endproperty
  a_flow: assert property (p_flow) else $error("flow read late");
  property p_turn; dq_host_oe |-> output_enable_n & !dq_mem_oe; endproperty
  a_turn: assert property (p_turn) else $error("bus contention");
  property p_proc; processor_addr_strobe_n; endproperty
  a_proc: assert property (p_proc) else $error("processor strobe used");
  property p_wdata; begin_wr |-> dq_host_oe; endproperty
  a_wdata: assert property (p_wdata) else $error("write without data");
  property p_sleep; sleep_request [*2] |-> ##1 !dq_mem_oe; endproperty
  a_sleep: assert property (p_sleep) else $error("drive in standby");
endmodule : sbsc_assertions

// >>> bench/sync_burst_sram_command_decode_test.sv
// self-checking bench: host and memory joined over the sram bus
`timescale 1ns/1ps
module sync_burst_sram_command_decode_test;
  import sbsc_pkg::*;
  logic clk = 0, reset = 1, clk_en = 1, reg_write = 0, reg_read = 0;
  logic [REG_ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic standby, write_done;
  logic [DATA_W-1:0] mem [int];
  int err_total = 0, checks = 0, cyc = 0, wcount = 0, seed = 32'h7BC4;
  sbsc_bus_if bus ();
  sbsc_memory u_sbsc_memory (.clk(clk), .reset(reset), .clk_en(clk_en), .bus(bus),
    .standby(standby), .write_done(write_done));
  sbsc_host u_sbsc_host (.clk(clk), .reset(reset), .clk_en(clk_en), .bus(bus),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  sbsc_assertions u_sbsc_assertions (.clk(clk), .reset(reset),
    .chip_enable_primary_n(bus.chip_enable_primary_n),
    .chip_enable_high_true(bus.chip_enable_high_true),
    .chip_enable_third_n(bus.chip_enable_third_n),
    .processor_addr_strobe_n(bus.processor_addr_strobe_n),
    .controller_addr_strobe_n(bus.controller_addr_strobe_n),
    .all_lane_write_n(bus.all_lane_write_n),
    .lane_write_qualifier_n(bus.lane_write_qualifier_n),
    .output_enable_n(bus.output_enable_n), .flow_through_select_n(bus.flow_through_select_n),
    .sleep_request(bus.sleep_request), .dq_host_oe(bus.dq_host_oe), .dq_mem_oe(bus.dq_mem_oe));
  // clock, write pulse count and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (write_done === 1'b1) wcount++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // compare and count
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  // register port cycles
  task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [REG_ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  // poll busy with a bound
  task automatic idle();
    logic [DATA_W-1:0] s;
    for (int i = 0; i < 40; i++) begin
      rd(REG_STATUS, s);
      if (s[0] === 1'b0) return;
    end
    check(s, '0);
  endtask : idle
  // one command through the registers, mirrored in the model
  task automatic run(input int a, input logic [1:0] op, input bit burst,
    input logic [3:0] lanes, input bit all, input bit il, input bit ft);
    logic [DATA_W-1:0] w [4];
    logic [DATA_W-1:0] d;
    int x;
    wr(REG_CTRL, DATA_W'({ft, il}));
    wr(REG_ADDR, DATA_W'(a));
    for (int k = 0; k < 4; k++) begin
      w[k] = DATA_W'({$random(seed), $random(seed)});
      wr(8'(REG_WDATA0 + 4 * k), w[k]);
    end
    wr(REG_CMD, DATA_W'({all, lanes, 1'b0, burst, op}));
    idle();
    for (int k = 0; k < (burst ? 4 : 1); k++) begin
      x = (a & ~3) | (il ? ((a ^ k) & 3) : ((a + k) & 3));
      d = mem.exists(x) ? mem[x] : 'x;
      if (op == OP_WRITE) begin
        for (int l = 0; l < LANES; l++)
          if (all || lanes[l]) d[l * LANE_W +: LANE_W] = w[k][l * LANE_W +: LANE_W];
        mem[x] = d;
      end else if (op == OP_READ) begin
        rd(8'(REG_RDATA0 + 4 * k), w[k]);
        check(w[k], d);
      end
    end
  endtask : run
  // closing report
  task automatic print_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    int a;
    bit b;
    logic [DATA_W-1:0] d;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    a = $random(seed) & 32'h3FFFF;
    run(a, OP_WRITE, 1, 4'h0, 1, 0, 0);
    check(DATA_W'(wcount), DATA_W'(4));
    run(a, OP_READ, 1, 4'h0, 0, 0, 0);
    run(a, OP_READ, 1, 4'h0, 0, 1, 1);
    for (int m = 0; m < 16; m++) begin
      run(a, OP_WRITE, 0, 4'(m), 0, 0, 0);
      run(a, OP_READ, 0, 4'h0, 0, 0, 0);
    end
    run(a, OP_DUMMY, 1, 4'h0, 0, 0, 0);
    check(DATA_W'(u_sbsc_memory.current_low), DATA_W'((a + 3) & 3));
    run(a, OP_WRITE, 1, 4'hF, 0, 1, 0);
    run(a, OP_READ, 1, 4'h0, 0, 1, 0);
    repeat (8) begin
      a = $random(seed) & 32'h3FFFF;
      b = 1'($random(seed));
      run(a, OP_WRITE, 1, 4'hF, 1'($random(seed)), b, 0);
      run(a, OP_READ, 1, 4'h0, 0, b, 1'($random(seed)));
    end
    wr(REG_CTRL, DATA_W'(4));
    repeat (3) @(posedge clk);
    #1;
    check(DATA_W'(standby), DATA_W'(1));
    wr(REG_CTRL, '0);
    repeat (3) @(posedge clk);
    #1;
    check(DATA_W'(standby), '0);
    rd(8'hC0, d);
    check(d, '0);
    print_verdict();
  end
endmodule : sync_burst_sram_command_decode_test
